/* hw/mss_device.sv */
// Sensor end: serial slave port, motion flag and line, power-mode downshift and
// pulsed illumination.
// Assumes link pins arrive asynchronously and the image side gives motion samples.
`timescale 1ns/1ps
module mss_device #(
  parameter longint DS1 = mss_pkg::DS1_CYC,
  parameter longint DS2 = mss_pkg::DS2_CYC,
  parameter longint DS3 = mss_pkg::DS3_CYC,
  parameter int FRAME_RUN = 200000,
  parameter int FRAME_REST1 = 1300000,
  parameter int FRAME_REST2 = 2000000,
  parameter int FRAME_REST3 = 4000000
) (
  input wire logic clock,
  input wire logic rst_b,
  mss_link_if.dev link,
  input wire logic motion_valid,
  input wire logic [7:0] dx_in,
  input wire logic [7:0] dy_in,
  input wire logic [7:0] surface_quality_in,
  input wire logic [15:0] exposure_in,
  input wire logic [7:0] peak_in,
  output logic frame_req,
  output logic illum_drive,
  output mss_pkg::mss_mode_type power_mode
);
  import mss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers. Logic reads the second stage, plus the third stage of the clock line for edges.
  logic ncs_s1, ncs_s2, sclk_s1, sclk_s2, sclk_q, mosi_s1, mosi_s2;
  logic sclk_rise, sclk_fall;

  // Two flops per pin, then a third for edge detection on the clock line.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ncs_s1 <= 1'b1;
      ncs_s2 <= 1'b1;
      sclk_s1 <= 1'b1;
      sclk_s2 <= 1'b1;
      sclk_q <= 1'b1;
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
    end else begin
      ncs_s1 <= link.ncs_b;
      ncs_s2 <= ncs_s1;
      sclk_s1 <= link.sclk;
      sclk_s2 <= sclk_s1;
      sclk_q <= sclk_s2;
      mosi_s1 <= link.mosi;
      mosi_s2 <= mosi_s1;
    end
  end

  assign sclk_rise = sclk_s2 & ~sclk_q;
  assign sclk_fall = ~sclk_s2 & sclk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Sensor data held for readout.
  logic mot_reg, mot_next, dy_seen_reg, dy_seen_next;
  logic [7:0] dx_reg, dx_next, dy_reg, dy_next;
  logic [7:0] sq_reg, sq_next, peak_reg, peak_next;
  logic [15:0] exp_reg, exp_next;
  logic motion_b_reg, motion_b_next;
  logic new_motion, clear_motion;
  logic rd_stb, wr_stb;
  logic [6:0] rd_addr;

  // Read multiplexer; unmapped addresses read as zero.
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    unique case (a)
      ADDR_MOTION: rd_byte = {mot_reg, 7'h00};
      ADDR_DY: rd_byte = dy_reg;
      ADDR_DX: rd_byte = dx_reg;
      ADDR_SURFACE_QUALITY: rd_byte = sq_reg;
      ADDR_EXP_HI: rd_byte = exp_reg[15:8];
      ADDR_EXP_LO: rd_byte = exp_reg[7:0];
      ADDR_PEAK: rd_byte = peak_reg;
      default: rd_byte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port state machine.
  mss_dev_state_type st_reg, st_next;
  logic [2:0] bit_reg, bit_next, idx_reg, idx_next;
  logic [7:0] sh_reg, sh_next, out_reg, out_next;
  logic [6:0] addr_reg, addr_next;
  logic burst_reg, burst_next, miso_reg, miso_next, oe_reg, oe_next;

  // Next-state logic; a raised select overrides everything and resets the port.
  always_comb begin
    st_next = st_reg;
    bit_next = bit_reg;
    idx_next = idx_reg;
    sh_next = sh_reg;
    out_next = out_reg;
    addr_next = addr_reg;
    burst_next = burst_reg;
    miso_next = miso_reg;
    oe_next = oe_reg;
    rd_stb = 1'b0;
    wr_stb = 1'b0;
    rd_addr = addr_reg;
    if (ncs_s2) begin
      st_next = DS_IDLE;
      oe_next = 1'b0;
      bit_next = 3'h0;
    end else begin
      unique case (st_reg)
        DS_IDLE: begin
          st_next = DS_ADDR;
          idx_next = 3'h0;
          burst_next = 1'b0;
        end
        DS_ADDR: begin
          if (sclk_rise) begin
            sh_next = {sh_reg[6:0], mosi_s2};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              addr_next = {sh_reg[5:0], mosi_s2};
              if (sh_reg[6]) begin
                st_next = DS_WDATA;
              end else begin
                st_next = DS_RDATA;
                // Data is latched right after the address, hence the address gap.
                if ({sh_reg[5:0], mosi_s2} == ADDR_BURST) begin
                  burst_next = 1'b1;
                  rd_addr = ADDR_MOTION;
                end else begin
                  rd_addr = {sh_reg[5:0], mosi_s2};
                end
                out_next = rd_byte(rd_addr);
                rd_stb = 1'b1;
              end
            end
          end
        end
        DS_WDATA: begin
          if (sclk_rise) begin
            sh_next = {sh_reg[6:0], mosi_s2};
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              wr_stb = 1'b1;
              st_next = DS_DONE;
            end
          end
        end
        DS_RDATA: begin
          if (sclk_fall) begin
            oe_next = 1'b1;
            miso_next = out_reg[7];
            out_next = {out_reg[6:0], 1'b0};
          end else if (sclk_rise) begin
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
              if (burst_reg && idx_reg != BURST_LAST) begin
                idx_next = idx_reg + 3'h1;
                rd_addr = ADDR_MOTION + {4'h0, idx_next};
                out_next = rd_byte(rd_addr);
                rd_stb = 1'b1;
              end else begin
                st_next = DS_DONE;
              end
            end
          end
        end
        DS_DONE: begin
          // Port stays locked until select is raised; early commands are lost.
          st_next = DS_DONE;
        end
        default: st_next = DS_IDLE;
      endcase
    end
  end

  // The port only answers edges the host makes; it never drives a transfer.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_reg <= DS_IDLE;
      bit_reg <= 3'h0;
      idx_reg <= 3'h0;
      sh_reg <= 8'h00;
      out_reg <= 8'h00;
      addr_reg <= 7'h00;
      burst_reg <= 1'b0;
      miso_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      sh_reg <= sh_next;
      out_reg <= out_next;
      addr_reg <= addr_next;
      burst_reg <= burst_next;
      miso_reg <= miso_next;
      oe_reg <= oe_next;
    end
  end

  assign link.miso = miso_reg;
  assign link.miso_oe = oe_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Motion flag and data; new motion wins over a clear in the same cycle.
  always_comb begin
    new_motion = motion_valid && (dx_in != 8'h00 || dy_in != 8'h00);
    clear_motion = (wr_stb && addr_reg == ADDR_MOTION) ||
      (rd_stb && rd_addr == ADDR_DX && dy_seen_reg);
    dx_next = clear_motion ? 8'h00 : dx_reg;
    dy_next = clear_motion ? 8'h00 : dy_reg;
    if (new_motion) begin
      dx_next = dx_next + dx_in;
      dy_next = dy_next + dy_in;
    end
    mot_next = new_motion | (mot_reg & ~clear_motion);
    dy_seen_next = clear_motion ? 1'b0 : (dy_seen_reg | (rd_stb && rd_addr == ADDR_DY));
    sq_next = motion_valid ? surface_quality_in : sq_reg;
    exp_next = motion_valid ? exposure_in : exp_reg;
    peak_next = motion_valid ? peak_in : peak_reg;
    motion_b_next = ~mot_next;
  end

  // Registers for the motion data group.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mot_reg <= 1'b0;
      dy_seen_reg <= 1'b0;
      dx_reg <= 8'h00;
      dy_reg <= 8'h00;
      sq_reg <= 8'h00;
      exp_reg <= 16'h0000;
      peak_reg <= 8'h00;
      motion_b_reg <= 1'b1;
    end else begin
      mot_reg <= mot_next;
      dy_seen_reg <= dy_seen_next;
      dx_reg <= dx_next;
      dy_reg <= dy_next;
      sq_reg <= sq_next;
      exp_reg <= exp_next;
      peak_reg <= peak_next;
      motion_b_reg <= motion_b_next;
    end
  end

  assign link.motion_b = motion_b_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Power modes and frame timing. Idle time is wide enough for the longest downshift.
  logic [36:0] idle_reg, idle_next;
  logic [23:0] frm_reg, frm_next;
  logic [7:0] led_reg, led_next;
  logic frame_next;
  mss_mode_type mode_reg, mode_next;

  // Frame period for each mode; longer periods save power at the cost of response.
  function automatic logic [23:0] frame_period(input mss_mode_type m);
    unique case (m)
      MODE_RUN: frame_period = 24'(FRAME_RUN);
      MODE_REST1: frame_period = 24'(FRAME_REST1);
      MODE_REST2: frame_period = 24'(FRAME_REST2);
      MODE_REST3: frame_period = 24'(FRAME_REST3);
    endcase
  endfunction

  // Downshift by time since motion; motion snaps back to run mode.
  always_comb begin
    idle_next = new_motion ? 37'h0 : ((idle_reg == 37'(DS3)) ? idle_reg : idle_reg + 37'h1);
    if (idle_next >= 37'(DS3)) begin
      mode_next = MODE_REST3;
    end else if (idle_next >= 37'(DS2)) begin
      mode_next = MODE_REST2;
    end else if (idle_next >= 37'(DS1)) begin
      mode_next = MODE_REST1;
    end else begin
      mode_next = MODE_RUN;
    end
    frame_next = (frm_reg == 24'h0);
    frm_next = frame_next ? frame_period(mode_reg) : frm_reg - 24'h1;
    // The light source is only lit for a short pulse per frame.
    led_next = frame_next ? 8'(ILLUM_CYC) : ((led_reg != 8'h00) ? led_reg - 8'h01 : 8'h00);
  end

  // Registers for the power group.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      idle_reg <= 37'h0;
      mode_reg <= MODE_RUN;
      frm_reg <= 24'h0;
      led_reg <= 8'h00;
      frame_req <= 1'b0;
      illum_drive <= 1'b0;
    end else begin
      idle_reg <= idle_next;
      mode_reg <= mode_next;
      frm_reg <= frm_next;
      led_reg <= led_next;
      frame_req <= frame_next;
      illum_drive <= (led_next != 8'h00);
    end
  end

  assign power_mode = mode_reg;
endmodule // mss_device

/* hw/mss_host.sv */
// Host end: APB-controlled serial master that frames each access with chip select
// and keeps every spacing the sensor needs.
// Assumes an APB master on the system clock; link inputs are asynchronous.
`timescale 1ns/1ps
module mss_host (
  input wire logic clock,
  input wire logic rst_b,
  mss_link_if.host link,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import mss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers.
  logic miso_s1, miso_s2, mot_s1, mot_s2, mot_q;

  // Two flops per input; mot_q feeds the edge detector.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
      mot_s1 <= 1'b1;
      mot_s2 <= 1'b1;
      mot_q <= 1'b1;
    end else begin
      miso_s1 <= link.miso_line;
      miso_s2 <= miso_s1;
      mot_s1 <= link.motion_b;
      mot_s2 <= mot_s1;
      mot_q <= mot_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave and transfer engine.
  mss_host_state_type st_reg, st_next;
  logic [11:0] tmr_reg, tmr_next;
  logic [2:0] bit_reg, bit_next, idx_reg, idx_next, cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next, cmd_addr_reg, cmd_addr_next, wdat_reg, wdat_next;
  logic [55:0] rd_reg, rd_next;
  logic ncs_reg, ncs_next, sclk_reg, sclk_next, mosi_reg, mosi_next;
  logic [1:0] ist_reg, ist_next, imask_reg, imask_next;
  logic [31:0] prd_next;
  logic irq_next, acc, last_byte, tx_bit;

  // Next values; a command written while busy is dropped.
  always_comb begin
    st_next = st_reg;
    tmr_next = (tmr_reg != 12'h0) ? tmr_reg - 12'h1 : 12'h0;
    bit_next = bit_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    cmd_addr_next = cmd_addr_reg;
    wdat_next = wdat_reg;
    rd_next = rd_reg;
    ncs_next = ncs_reg;
    sclk_next = sclk_reg;
    mosi_next = mosi_reg;
    imask_next = imask_reg;
    ist_next = ist_reg;
    acc = psel & penable;
    last_byte = cmd_addr_reg[CMD_WR_BIT] ? (idx_reg == 3'h1) : (idx_reg == cnt_reg);
    // Read data phases send zeros, so bits shifted in from the sensor never echo back out.
    tx_bit = (idx_reg == 3'h0 || cmd_addr_reg[CMD_WR_BIT]) ? sh_reg[7] : 1'b0;
    unique case (paddr)
      OFS_STATUS: prd_next = {30'h0, ~mot_s2, st_reg != HS_IDLE};
      OFS_RDATA0: prd_next = rd_reg[31:0];
      OFS_RDATA1: prd_next = {8'h00, rd_reg[55:32]};
      OFS_INT_STAT: prd_next = {30'h0, ist_reg};
      OFS_INT_MASK: prd_next = {30'h0, imask_reg};
      default: prd_next = 32'h0;
    endcase
    // Only bits already latched into the read data are cleared, so an event that lands
    // between the setup and access cycles is still reported by the next read.
    if (acc && !pwrite && paddr == OFS_INT_STAT) begin
      ist_next = ist_reg & ~prdata[1:0];
    end
    if (acc && pwrite && paddr == OFS_INT_MASK) begin
      imask_next = pwdata[1:0];
    end
    if (acc && pwrite && paddr == OFS_CMD && st_reg == HS_IDLE) begin
      cmd_addr_next = pwdata[7:0];
      wdat_next = pwdata[CMD_DATA_LSB +: 8];
      cnt_next = (pwdata[CMD_CNT_LSB +: 3] == 3'h0) ? 3'h1 : pwdata[CMD_CNT_LSB +: 3];
      sh_next = pwdata[7:0];
      idx_next = 3'h0;
      bit_next = 3'h0;
      ncs_next = 1'b0;
      tmr_next = 12'(NCS_SCLK_CYC);
      st_next = HS_LEAD;
    end
    unique case (st_reg)
      HS_IDLE: ;
      HS_LEAD, HS_RAD: begin
        if (tmr_reg == 12'h0) begin
          sclk_next = 1'b0;
          mosi_next = tx_bit;
          tmr_next = 12'(HALF_CYC);
          st_next = HS_LOW;
        end
      end
      HS_LOW: begin
        if (tmr_reg == 12'h0) begin
          sclk_next = 1'b1;
          sh_next = {sh_reg[6:0], miso_s2};
          tmr_next = 12'(HALF_CYC);
          st_next = HS_HIGH;
        end
      end
      HS_HIGH: begin
        if (tmr_reg == 12'h0) begin
          bit_next = bit_reg + 3'h1;
          if (bit_reg != 3'h7) begin
            sclk_next = 1'b0;
            mosi_next = tx_bit;
            tmr_next = 12'(HALF_CYC);
            st_next = HS_LOW;
          end else begin
            idx_next = idx_reg + 3'h1;
            if (idx_reg != 3'h0) begin
              rd_next[{idx_reg - 3'h1, 3'h0} +: 8] = sh_reg;
            end
            if (last_byte) begin
              tmr_next = cmd_addr_reg[CMD_WR_BIT] ? 12'(HOLD_WR_CYC) : 12'(HOLD_RD_CYC);
              st_next = HS_HOLD;
            end else if (idx_reg == 3'h0 && !cmd_addr_reg[CMD_WR_BIT]) begin
              tmr_next = 12'(RAD_CYC);
              st_next = HS_RAD;
            end else begin
              sh_next = wdat_reg;
              sclk_next = 1'b0;
              mosi_next = cmd_addr_reg[CMD_WR_BIT] ? wdat_reg[7] : 1'b0;
              tmr_next = 12'(HALF_CYC);
              st_next = HS_LOW;
            end
          end
        end
      end
      HS_HOLD: begin
        if (tmr_reg == 12'h0) begin
          ncs_next = 1'b1;
          tmr_next = 12'(GAP_CYC);
          st_next = HS_GAP;
        end
      end
      HS_GAP: begin
        if (tmr_reg == 12'h0) begin
          st_next = HS_IDLE;
          ist_next[INT_DONE] = 1'b1;
        end
      end
      default: st_next = HS_IDLE;
    endcase
    // Events are set after the read clear so a coincident event is kept.
    if (!mot_s2 && mot_q) begin
      ist_next[INT_MOTION] = 1'b1;
    end
    irq_next = |(ist_next & imask_next);
  end

  // Registers for the host; the link idles deselected with the clock high.
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      st_reg <= HS_IDLE;
      tmr_reg <= 12'h0;
      bit_reg <= 3'h0;
      idx_reg <= 3'h0;
      cnt_reg <= 3'h1;
      sh_reg <= 8'h00;
      cmd_addr_reg <= 8'h00;
      wdat_reg <= 8'h00;
      rd_reg <= 56'h0;
      ncs_reg <= 1'b1;
      sclk_reg <= 1'b1;
      mosi_reg <= 1'b0;
      ist_reg <= 2'h0;
      imask_reg <= 2'h0;
      prdata <= 32'h0;
      irq <= 1'b0;
    end else begin
      st_reg <= st_next;
      tmr_reg <= tmr_next;
      bit_reg <= bit_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      cmd_addr_reg <= cmd_addr_next;
      wdat_reg <= wdat_next;
      rd_reg <= rd_next;
      ncs_reg <= ncs_next;
      sclk_reg <= sclk_next;
      mosi_reg <= mosi_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      if (psel && !penable) begin
        prdata <= prd_next;
      end
      irq <= irq_next;
    end
  end

  assign pready = psel & penable;
  assign pslverr = psel & penable & (paddr > OFS_INT_MASK || paddr[1:0] != 2'b00);
  assign link.ncs_b = ncs_reg;
  assign link.sclk = sclk_reg;
  assign link.mosi = mosi_reg;
endmodule // mss_host

/* hw/mss_link_if.sv */
// Four-wire serial link between host controller and sensor, plus the motion line.
// Assumes a testbench instantiates it and joins both ends.
`timescale 1ns/1ps
interface mss_link_if;
  logic ncs_b;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic motion_b;
  logic miso_line;
  // A released line shows the inverse of the last bit, so a host that samples it too
  // early or too late reads a wrong value rather than a plausible one.
  assign miso_line = miso_oe ? miso : ~miso;
  modport dev (input ncs_b, input sclk, input mosi, output miso, output miso_oe,
    output motion_b);
  modport host (output ncs_b, output sclk, output mosi, input miso_line,
    input motion_b);
endinterface // mss_link_if

/* hw/mss_pkg.sv */
// Shared constants for the motion sensor serial port: link timing, register addresses,
// field layouts and state encodings.
// Assumes a 200 MHz system clock on both ends.
package mss_pkg;
  localparam int CLK_NS = 5;
  // Link timing figures in their own units, then cycles (least times round up).
  localparam int T_WR_RD_US = 20;
  localparam int T_RD_NEXT_NS = 500;
  localparam int T_RAD_US = 4;
  localparam int T_BEXIT_NS = 500;
  localparam int T_NCS_SCLK_NS = 120;
  localparam int T_HOLD_RD_NS = 120;
  localparam int T_HOLD_WR_US = 20;
  localparam int T_SCLK_HALF_NS = 500;
  localparam int WR_RD_CYC = (T_WR_RD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int RD_NEXT_CYC = (T_RD_NEXT_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAD_CYC = (T_RAD_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int BEXIT_CYC = (T_BEXIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int NCS_SCLK_CYC = (T_NCS_SCLK_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_RD_CYC = (T_HOLD_RD_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_WR_CYC = (T_HOLD_WR_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC = T_SCLK_HALF_NS / CLK_NS;
  localparam int GAP_CYC = (BEXIT_CYC > RD_NEXT_CYC) ? BEXIT_CYC : RD_NEXT_CYC;
  // Power-saving downshift times (8.4 s kept as 84 tenths).
  localparam longint DS1_MS = 237;
  localparam longint DS2_DS = 84;
  localparam longint DS3_S = 504;
  localparam longint DS1_CYC = DS1_MS * 1000000 / CLK_NS;
  localparam longint DS2_CYC = DS2_DS * 100000000 / CLK_NS;
  localparam longint DS3_CYC = DS3_S * 1000000000 / CLK_NS;
  localparam int ILLUM_CYC = 20;
  // Device register addresses and fields.
  localparam logic [6:0] ADDR_MOTION = 7'h02;
  localparam logic [6:0] ADDR_DY = 7'h03;
  localparam logic [6:0] ADDR_DX = 7'h04;
  localparam logic [6:0] ADDR_SURFACE_QUALITY = 7'h05;
  localparam logic [6:0] ADDR_EXP_HI = 7'h06;
  localparam logic [6:0] ADDR_EXP_LO = 7'h07;
  localparam logic [6:0] ADDR_PEAK = 7'h08;
  localparam logic [6:0] ADDR_BURST = 7'h42;
  localparam int MOTION_BIT = 7;
  localparam int MODE_LSB = 0;
  localparam logic [2:0] BURST_LAST = 3'h6;
  // Host APB register offsets and fields.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RDATA0 = 8'h08;
  localparam logic [7:0] OFS_RDATA1 = 8'h0C;
  localparam logic [7:0] OFS_INT_STAT = 8'h10;
  localparam logic [7:0] OFS_INT_MASK = 8'h14;
  localparam int CMD_WR_BIT = 7;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_CNT_LSB = 16;
  localparam int INT_DONE = 0;
  localparam int INT_MOTION = 1;
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, MODE_REST1 = 2'b01, MODE_REST2 = 2'b10, MODE_REST3 = 2'b11
  } mss_mode_type;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000, DS_ADDR = 3'b001, DS_WDATA = 3'b010, DS_RDATA = 3'b011,
    DS_DONE = 3'b100
  } mss_dev_state_type;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000, HS_LEAD = 3'b001, HS_LOW = 3'b010, HS_HIGH = 3'b011,
    HS_RAD = 3'b100, HS_HOLD = 3'b101, HS_GAP = 3'b110
  } mss_host_state_type;
endpackage

/* tb/motion_sensor_serial_port_test.sv */
// Bench joining host and sensor ends; drives APB and motion samples.
// Assumes the design files and the link checker are compiled first.
`timescale 1ns/1ps
module motion_sensor_serial_port_test;
  import mss_pkg::*;
  logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, mv = 0;
  logic [7:0] paddr = 8'h00, dx = 8'h00, dy = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0] sq = 8'h33, pk = 8'h77;
  logic [15:0] ex = 16'h1234;
  logic pready, pslverr, irq, err, illum_drive, frame_req;
  mss_mode_type power_mode;
  int fails = 0, compares = 0, cyc = 0, n, f;
  mss_link_if mss_link_if_inst ();
  // Short downshift times and run-mode frames keep the run brief; rest-mode frame periods
  // keep their long defaults, so only frames that close a run-mode period are counted.
  mss_device #(.DS1(1000), .DS2(2000), .DS3(3000), .FRAME_RUN(200)) mss_device_inst (
    .clock(clock), .rst_b(rst_b),
    .link(mss_link_if_inst), .motion_valid(mv), .dx_in(dx), .dy_in(dy),
    .surface_quality_in(sq), .exposure_in(ex), .peak_in(pk),
    .frame_req(frame_req), .illum_drive(illum_drive), .power_mode(power_mode));
  mss_host mss_host_inst (.clock(clock), .rst_b(rst_b), .link(mss_link_if_inst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
  mss_link_sva mss_link_sva_inst (.clock(clock), .rst_b(rst_b),
    .ncs_b(mss_link_if_inst.ncs_b), .sclk(mss_link_if_inst.sclk),
    .miso(mss_link_if_inst.miso), .miso_oe(mss_link_if_inst.miso_oe),
    .motion_b(mss_link_if_inst.motion_b));
  ////////////////////////////////////////////////////////////////////////////////
  // Free-running clock and a cycle limit that cuts a hang short.
  initial forever #2.5 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      results();
    end
  end
  task automatic results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'h1;
    @(posedge clock);
    while (pready !== 1'h1) @(posedge clock);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  // Issue a link command and poll until the host is idle again.
  task automatic cmd(input logic [31:0] v);
    apb(1'h1, OFS_CMD, v);
    do apb(1'h0, OFS_STATUS, 32'h0); while (rd[0] !== 1'h0);
  endtask
  task automatic pulse(input logic [7:0] y, input logic [7:0] x);
    mv <= 1'h1;
    dy <= y;
    dx <= x;
    @(posedge clock) mv <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: illumination, interrupts, burst, single reads, clear by write, modes.
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'h1;
    repeat (120) @(posedge clock);
    check("mode reset", power_mode, MODE_RUN);
    // Sampled mid-cycle so registered outputs are settled; five run frames fall in here.
    n = 0;
    f = 0;
    repeat (1000) @(negedge clock) begin
      n += illum_drive;
      f += frame_req;
    end
    check("illum pulsed", n >= 80 && n <= 120, 1'h1);
    check("frame count", f >= 4 && f <= 6, 1'h1);
    @(posedge clock);
    apb(1'h1, OFS_INT_MASK, 32'h1);
    apb(1'h0, 8'h18, 32'h0);
    check("unmapped err", err, 1'h1);
    check("unmapped data", rd, 32'h0);
    pulse(8'h05, 8'hFA);
    check("motion low", mss_link_if_inst.motion_b, 1'h0);
    check("irq masked", irq, 1'h0);
    apb(1'h1, OFS_INT_MASK, 32'h3);
    check("irq raised", irq, 1'h1);
    apb(1'h0, OFS_INT_STAT, 32'h0);
    check("int stat", rd[1:0], 2'h2);
    check("irq cleared", irq, 1'h0);
    cmd(32'h0007_0042);
    apb(1'h0, OFS_RDATA0, 32'h0);
    check("burst lo", {rd[31:8], rd[7]}, {24'h33FA05, 1'h1});
    apb(1'h0, OFS_RDATA1, 32'h0);
    check("burst hi", rd[23:0], 24'h773412);
    check("burst clear", mss_link_if_inst.motion_b, 1'h1);
    pulse(8'h01, 8'h02);
    cmd(32'h0000_0003);
    check("pending", rd[1], 1'h1);
    apb(1'h0, OFS_RDATA0, 32'h0);
    check("dy", {mss_link_if_inst.motion_b, rd[7:0]}, 9'h001);
    cmd(32'h0000_0004);
    apb(1'h0, OFS_RDATA0, 32'h0);
    check("dx", {mss_link_if_inst.motion_b, rd[7:0]}, 9'h102);
    pulse(8'h03, 8'h04);
    cmd(32'h0000_0082);
    check("write clear", mss_link_if_inst.motion_b, 1'h1);
    check("mode rest3", power_mode, MODE_REST3);
    pulse(8'h01, 8'h01);
    repeat (10) @(posedge clock);
    check("mode run", power_mode, MODE_RUN);
    repeat (1000) @(posedge clock);
    check("mode rest1", power_mode, MODE_REST1);
    repeat (1000) @(posedge clock);
    check("mode rest2", power_mode, MODE_REST2);
    results();
  end
endmodule // motion_sensor_serial_port_test

/* tb/mss_link_sva.sv */
// Checker for the serial link between the host end and the sensor end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
module mss_link_sva (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ncs_b,
  input wire logic sclk,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic motion_b
);
  localparam int RAD_MIN = 800;
  int hi_cnt;
  int last_hi;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  // Length of the latest high phase, so the address-to-data gap can be judged.
  always_ff @(posedge clock) begin
    hi_cnt <= sclk ? hi_cnt + 1 : 0;
    last_hi <= (!sclk && hi_cnt != 0) ? hi_cnt : last_hi;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // A sampled output lags the pin by a few clocks, so bounds allow that slack.
  a_desel_tristate: assert property (ncs_b [*8] |-> !miso_oe)
    else $error("sensor drives its output while deselected");
  a_release_bound: assert property ($rose(ncs_b) |-> ##[1:100] !miso_oe)
    else $error("output not released in time after deselect");
  a_no_self_start: assert property ($rose(miso_oe) |-> !ncs_b)
    else $error("sensor started driving without selection");
  a_drive_on_fall: assert property (miso_oe && $past(miso_oe) && $changed(miso)
    |-> !$past(sclk, 2))
    else $error("sensor output changed outside a low clock phase");
  a_select_lead: assert property ($fell(sclk) |-> !$past(ncs_b, 24))
    else $error("clock edge too soon after select");
  a_select_hold: assert property ($rose(ncs_b) |-> $past(sclk, 24))
    else $error("select released too soon after last clock edge");
  a_deselect_gap: assert property ($fell(ncs_b) |-> $past(ncs_b, 100))
    else $error("select idle time too short");
  a_addr_data_gap: assert property ($rose(miso_oe) |-> last_hi >= RAD_MIN)
    else $error("data phase began too soon after address");
  c_read_data: cover property ($rose(miso_oe));
  c_motion_set: cover property ($fell(motion_b));
  c_motion_clear: cover property ($rose(motion_b));
endmodule // mss_link_sva
